// [hdl/pgf_pkg.sv]
// constants and types for the generator update and fault control block
`default_nettype none
package pgf_pkg;
    // ********************************
    // widths
    // ********************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int VAL_W  = 16;
    localparam int MFP_W  = 16;
    localparam int NPIN   = 4;
    localparam int NCMP   = 4;
    localparam int NSH    = 4;

    // ********************************
    // register offsets
    // ********************************
    localparam logic [ADDR_W-1:0] OFS_CTL    = 8'h40;
    localparam logic [ADDR_W-1:0] OFS_DBFALL = 8'h44;
    localparam logic [ADDR_W-1:0] OFS_DBRISE = 8'h48;
    localparam logic [ADDR_W-1:0] OFS_DBCTL  = 8'h4C;
    localparam logic [ADDR_W-1:0] OFS_GENB   = 8'h50;
    localparam logic [ADDR_W-1:0] OFS_MINFLT = 8'h54;
    localparam logic [ADDR_W-1:0] OFS_FLTIN  = 8'h58;
    localparam logic [ADDR_W-1:0] OFS_CMPSRC = 8'h5C;

    // ********************************
    // control field layout and values
    // ********************************
    localparam int CTL_LSB       = 8;
    localparam int CTL_MSB       = 17;
    localparam int CTL_MINFLT    = 17;
    localparam int CTL_SRC       = 16;
    localparam int CTL_FALL_LSB  = 14;
    localparam int CTL_RISE_LSB  = 12;
    localparam int CTL_DBCTL_LSB = 10;
    localparam int CTL_GENB_LSB  = 8;
    localparam logic [1:0] MODE_IMM    = 2'h0;
    localparam logic [1:0] MODE_RSVD   = 2'h1;
    localparam logic [1:0] MODE_LOCAL  = 2'h2;
    localparam logic [1:0] MODE_GLOBAL = 2'h3;
    localparam logic [DATA_W-1:0] RST_VAL = 32'h0000_0000;

    // shadow slots
    localparam int SH_FALL = 0;
    localparam int SH_RISE = 1;
    localparam int SH_CTL  = 2;
    localparam int SH_GENB = 3;

    typedef struct packed {
        logic       min_fault_extend_en;
        logic       fault_source_select;
        logic [1:0] deadband_fall_update_mode;
        logic [1:0] deadband_rise_update_mode;
        logic [1:0] deadband_ctl_update_mode;
        logic [1:0] gen_b_action_update_mode;
    } pgf_ctl_t;

    typedef enum logic {PGF_IDLE, PGF_STRETCH} pgf_state_t;
endpackage
`default_nettype wire

// [hdl/pgf_ctl.sv]
// generator control: fault source, fault stretch and register update modes
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`default_nettype none
// Notes on behaviour
// - with the extend enable clear the fault ends as soon as its source drops.
// - with the extend enable set a one-shot stretches each fault that starts outside a stretch to the programmed minimum.
// - source select bit 16 at 0 takes fault input zero as the fault condition.
// - source select at 1 forms the fault from the fault input and comparator select registers.
// - update mode 0 applies a write at once, and the reserved mode 1 behaves the same here.
// - update mode 2 holds a write pending until the next counter zero.
// - update mode 3 holds a write until a sync request, then applies it at the next zero.
// - fields 15:14, 13:12 and 11:10 govern dead-band fall, dead-band rise and dead-band control.
// - field 9:8 governs the generator-B action register with the same encoding.
// - the stretch lasts the minimum count plus one cycles after the synchronised edge.
// - clearing the enable aborts a stretch, and the one-shot ignores src while counting.
module pgf_ctl
    import pgf_pkg::*;
(
    // clock and reset
    input  wire logic              I_CLK,
    input  wire logic              I_RST,
    input  wire logic              I_CE,
    // register port
    input  wire logic [ADDR_W-1:0] I_ADDR,
    input  wire logic [DATA_W-1:0] I_WDATA,
    input  wire logic              I_WR,
    input  wire logic              I_RD,
    output logic      [DATA_W-1:0] O_RDATA,
    // generator timing
    input  wire logic              I_CNT_ZERO,
    input  wire logic              I_SYNC_REQ,
    // fault sources
    input  wire logic [NPIN-1:0]   I_FAULT_PIN,
    input  wire logic [NCMP-1:0]   I_CMP_TRIG,
    output logic                   O_FAULT,
    // active values seen by the generator
    output logic      [VAL_W-1:0]  O_DBFALL,
    output logic      [VAL_W-1:0]  O_DBRISE,
    output logic      [VAL_W-1:0]  O_DBCTL,
    output logic      [VAL_W-1:0]  O_GENB
);
    // ********************************
    // functions
    // ********************************
    function automatic logic [1:0] mode_of(input pgf_ctl_t c, input int i);
        unique case (i)
            SH_FALL: mode_of = c.deadband_fall_update_mode;
            SH_RISE: mode_of = c.deadband_rise_update_mode;
            SH_CTL:  mode_of = c.deadband_ctl_update_mode;
            default: mode_of = c.gen_b_action_update_mode;
        endcase
    endfunction

    function automatic logic [ADDR_W-1:0] ofs_of(input int i);
        unique case (i)
            SH_FALL: ofs_of = OFS_DBFALL;
            SH_RISE: ofs_of = OFS_DBRISE;
            SH_CTL:  ofs_of = OFS_DBCTL;
            default: ofs_of = OFS_GENB;
        endcase
    endfunction

    // ********************************
    // register state
    // ********************************
    pgf_ctl_t                 ctl;
    pgf_ctl_t                 next_ctl;
    logic [MFP_W-1:0]         min_fault_count;
    logic [MFP_W-1:0]         next_min_fault_count;
    logic [NPIN-1:0]          fltin;
    logic [NPIN-1:0]          next_fltin;
    logic [NCMP-1:0]          cmpsrc;
    logic [NCMP-1:0]          next_cmpsrc;
    logic [VAL_W-1:0]         shadow [NSH];
    logic [VAL_W-1:0]         next_shadow [NSH];
    logic [VAL_W-1:0]         active [NSH];
    logic [VAL_W-1:0]         next_active [NSH];
    logic [NSH-1:0]           pend;
    logic [NSH-1:0]           next_pend;
    logic [NSH-1:0]           armed;
    logic [NSH-1:0]           next_armed;
    logic [DATA_W-1:0]        rdata;
    logic [DATA_W-1:0]        next_rdata;

    always_comb begin
        next_ctl             = ctl;
        next_min_fault_count = min_fault_count;
        next_fltin           = fltin;
        next_cmpsrc          = cmpsrc;
        next_shadow          = shadow;
        next_active          = active;
        next_pend            = pend;
        next_armed           = armed;
        next_rdata           = RST_VAL;
        if (I_WR) begin
            unique case (I_ADDR)
                OFS_CTL:    next_ctl = I_WDATA[CTL_MSB:CTL_LSB];
                OFS_MINFLT: next_min_fault_count = I_WDATA[MFP_W-1:0];
                OFS_FLTIN:  next_fltin = I_WDATA[NPIN-1:0];
                OFS_CMPSRC: next_cmpsrc = I_WDATA[NCMP-1:0];
                default:    next_ctl = ctl;
            endcase
        end
        for (int i = 0; i < NSH; i++) begin
            // a sync request arms a slot that is already waiting, or a global-mode slot written in the same cycle
            if (pend[i] && I_SYNC_REQ) begin
                next_armed[i] = 1'b1;
            end
            if (pend[i]) begin
                unique case (mode_of(ctl, i))
                    MODE_LOCAL: if (I_CNT_ZERO) begin
                        next_active[i] = shadow[i];
                        next_pend[i]   = 1'b0;
                        next_armed[i]  = 1'b0;
                    end
                    MODE_GLOBAL: if (I_CNT_ZERO && armed[i]) begin
                        next_active[i] = shadow[i];
                        next_pend[i]   = 1'b0;
                        next_armed[i]  = 1'b0;
                    end
                    default: begin
                        next_active[i] = shadow[i];
                        next_pend[i]   = 1'b0;
                        next_armed[i]  = 1'b0;
                    end
                endcase
            end
            // a new write wins over an apply in the same cycle
            if (I_WR && I_ADDR == ofs_of(i)) begin
                next_shadow[i] = I_WDATA[VAL_W-1:0];
                if (mode_of(ctl, i) == MODE_IMM || mode_of(ctl, i) == MODE_RSVD) begin
                    next_active[i] = I_WDATA[VAL_W-1:0];
                    next_pend[i]   = 1'b0;
                    next_armed[i]  = 1'b0;
                end else begin
                    next_pend[i]  = 1'b1;
                    next_armed[i] = I_SYNC_REQ && mode_of(ctl, i) == MODE_GLOBAL;
                end
            end
        end
        if (I_RD) begin
            if (I_ADDR == OFS_CTL) begin
                next_rdata[CTL_MSB:CTL_LSB] = ctl;
            end else if (I_ADDR == OFS_MINFLT) begin
                next_rdata[MFP_W-1:0] = min_fault_count;
            end else if (I_ADDR == OFS_FLTIN) begin
                next_rdata[NPIN-1:0] = fltin;
            end else if (I_ADDR == OFS_CMPSRC) begin
                next_rdata[NCMP-1:0] = cmpsrc;
            end
            for (int i = 0; i < NSH; i++) begin
                if (I_ADDR == ofs_of(i)) begin
                    next_rdata[VAL_W-1:0] = shadow[i];
                end
            end
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            ctl             <= '0;
            min_fault_count <= '0;
            fltin           <= '0;
            cmpsrc          <= '0;
            shadow          <= '{default: '0};
            active          <= '{default: '0};
            pend            <= '0;
            armed           <= '0;
            rdata           <= RST_VAL;
        end else if (I_CE) begin
            ctl             <= next_ctl;
            min_fault_count <= next_min_fault_count;
            fltin           <= next_fltin;
            cmpsrc          <= next_cmpsrc;
            shadow          <= next_shadow;
            active          <= next_active;
            pend            <= next_pend;
            armed           <= next_armed;
            rdata           <= next_rdata;
        end
    end

    // ********************************
    // fault source and stretch
    // ********************************
    logic [NPIN-1:0]  sync1;
    logic [NPIN-1:0]  sync2;
    logic             src_q;
    logic             fault_q;
    logic             next_fault;
    pgf_state_t       state;
    pgf_state_t       next_state;
    logic [MFP_W-1:0] cnt;
    logic [MFP_W-1:0] next_cnt;
    logic             src;

    always_comb begin
        // pins are asynchronous, comparator events are already on this clock
        if (ctl.fault_source_select) begin
            src = |(sync2 & fltin) | |(I_CMP_TRIG & cmpsrc);
        end else begin
            src = sync2[0];
        end
        next_state = state;
        next_cnt   = cnt;
        unique case (state)
            PGF_IDLE: if (ctl.min_fault_extend_en && src && !src_q) begin
                next_state = PGF_STRETCH;
                next_cnt   = min_fault_count;
            end
            PGF_STRETCH: begin
                if (!ctl.min_fault_extend_en || cnt == '0) begin
                    next_state = PGF_IDLE;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
        endcase
        // the stretch also holds the fault while the one-shot runs
        next_fault = src || (next_state == PGF_STRETCH);
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            sync1   <= '0;
            sync2   <= '0;
            src_q   <= 1'b0;
            fault_q <= 1'b0;
            state   <= PGF_IDLE;
            cnt     <= '0;
        end else if (I_CE) begin
            sync1   <= I_FAULT_PIN;
            sync2   <= sync1;
            src_q   <= src;
            fault_q <= next_fault;
            state   <= next_state;
            cnt     <= next_cnt;
        end
    end

    assign O_RDATA  = rdata;
    assign O_FAULT  = fault_q;
    assign O_DBFALL = active[SH_FALL];
    assign O_DBRISE = active[SH_RISE];
    assign O_DBCTL  = active[SH_CTL];
    assign O_GENB   = active[SH_GENB];

    // ********************************
    // assertions
    // ********************************
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);

    AST_NO_EXTEND: assert property (I_CE && !ctl.min_fault_extend_en
        |=> O_FAULT == $past(src))
        else $error("fault extended while extend disabled");
    AST_STRETCH_START: assert property (I_CE && state == PGF_IDLE
        && ctl.min_fault_extend_en && src && !src_q
        |=> state == PGF_STRETCH && cnt == $past(min_fault_count))
        else $error("stretch did not load count");
    AST_SRC_PIN: assert property (!ctl.fault_source_select |-> src == sync2[0])
        else $error("pin source wrong");
    AST_SRC_REG: assert property (ctl.fault_source_select |-> src ==
        (|(sync2 & fltin) | |(I_CMP_TRIG & cmpsrc)))
        else $error("register source wrong");
    AST_IMM_FALL: assert property (I_CE && I_WR && I_ADDR == OFS_DBFALL
        && ctl.deadband_fall_update_mode == MODE_IMM
        |=> O_DBFALL == $past(I_WDATA[VAL_W-1:0]))
        else $error("immediate update missed");
    AST_LOCAL_ZERO: assert property (I_CE && pend[SH_RISE] && I_CNT_ZERO && !I_WR
        && ctl.deadband_rise_update_mode == MODE_LOCAL |=> O_DBRISE == $past(shadow[SH_RISE])
        && !pend[SH_RISE])
        else $error("local update missed at zero");
    AST_GLOBAL_HOLD: assert property (I_CE && pend[SH_CTL] && !armed[SH_CTL]
        && !I_WR && ctl.deadband_ctl_update_mode == MODE_GLOBAL
        |=> O_DBCTL == $past(O_DBCTL))
        else $error("global update applied without request");
    AST_CTL_FIELDS: assert property (I_CE && I_WR && I_ADDR == OFS_CTL |=>
        ctl.deadband_fall_update_mode == $past(I_WDATA[CTL_FALL_LSB+1:CTL_FALL_LSB])
        && ctl.deadband_ctl_update_mode == $past(I_WDATA[CTL_DBCTL_LSB+1:CTL_DBCTL_LSB]))
        else $error("mode field layout wrong");
    AST_GENB_IMM: assert property (I_CE && I_WR && I_ADDR == OFS_GENB
        && ctl.gen_b_action_update_mode == MODE_IMM
        |=> O_GENB == $past(I_WDATA[VAL_W-1:0]))
        else $error("genb immediate update missed");
    AST_COUNT_DOWN: assert property (I_CE && state == PGF_STRETCH && cnt != '0
        && ctl.min_fault_extend_en |=> cnt == $past(cnt) - 1'b1 && O_FAULT)
        else $error("stretch count wrong");
    AST_ABORT: assert property (I_CE && state == PGF_STRETCH
        && !ctl.min_fault_extend_en |=> state == PGF_IDLE)
        else $error("stretch not aborted");

    COV_STRETCH: cover property (state == PGF_STRETCH ##1 state == PGF_IDLE);
    COV_GLOBAL: cover property (armed[SH_GENB] && I_CNT_ZERO);
    COV_LOCAL: cover property (pend[SH_FALL] && I_CNT_ZERO
        && ctl.deadband_fall_update_mode == MODE_LOCAL);
endmodule
`default_nettype wire

// [verif/pgf_ctl_tb.sv]
// self-checking bench for the generator update and fault control block
`default_nettype none
module pgf_ctl_tb
    import pgf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ********************************
    // stimulus and observed signals
    // ********************************
    logic              I_CLK       = 1'b0;
    logic              I_RST       = 1'b1;
    logic              I_CE        = 1'b1;
    logic [ADDR_W-1:0] I_ADDR      = '0;
    logic [DATA_W-1:0] I_WDATA     = '0;
    logic              I_WR        = 1'b0;
    logic              I_RD        = 1'b0;
    logic              I_CNT_ZERO  = 1'b0;
    logic              I_SYNC_REQ  = 1'b0;
    logic [NPIN-1:0]   I_FAULT_PIN = '0;
    logic [NCMP-1:0]   I_CMP_TRIG  = '0;
    logic [DATA_W-1:0] O_RDATA;
    logic              O_FAULT;
    logic [VAL_W-1:0]  O_DBFALL;
    logic [VAL_W-1:0]  O_DBRISE;
    logic [VAL_W-1:0]  O_DBCTL;
    logic [VAL_W-1:0]  O_GENB;

    typedef struct {
        int                slot;
        logic [ADDR_W-1:0] addr;
        int                lsb;
        logic [1:0]        mode;
        logic [VAL_W-1:0]  data;
    } pgf_row_t;

    // every mode on every slot would not fit, so modes are spread over the slots
    pgf_row_t rows [8] = '{
        '{SH_FALL, OFS_DBFALL, CTL_FALL_LSB,  MODE_IMM,    16'h1111},
        '{SH_FALL, OFS_DBFALL, CTL_FALL_LSB,  MODE_GLOBAL, 16'h2222},
        '{SH_RISE, OFS_DBRISE, CTL_RISE_LSB,  MODE_RSVD,   16'h3333},
        '{SH_RISE, OFS_DBRISE, CTL_RISE_LSB,  MODE_LOCAL,  16'h4444},
        '{SH_CTL,  OFS_DBCTL,  CTL_DBCTL_LSB, MODE_LOCAL,  16'h5555},
        '{SH_CTL,  OFS_DBCTL,  CTL_DBCTL_LSB, MODE_GLOBAL, 16'h6666},
        '{SH_GENB, OFS_GENB,   CTL_GENB_LSB,  MODE_IMM,    16'h7777},
        '{SH_GENB, OFS_GENB,   CTL_GENB_LSB,  MODE_GLOBAL, 16'h8888}};

    logic [VAL_W-1:0]  act [4] = '{default: '0};
    logic [DATA_W-1:0] rdv;
    logic [DATA_W-1:0] ctl;
    int                fails       = 0;
    int                comparisons = 0;
    int                cycles      = 0;
    int                cnt;

    pgf_ctl i_pgf_ctl (
        .I_CLK(I_CLK), .I_RST(I_RST), .I_CE(I_CE), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
        .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_CNT_ZERO(I_CNT_ZERO),
        .I_SYNC_REQ(I_SYNC_REQ), .I_FAULT_PIN(I_FAULT_PIN), .I_CMP_TRIG(I_CMP_TRIG),
        .O_FAULT(O_FAULT), .O_DBFALL(O_DBFALL), .O_DBRISE(O_DBRISE), .O_DBCTL(O_DBCTL),
        .O_GENB(O_GENB));

    initial begin
        forever #5 I_CLK = ~I_CLK;
    end

    // a hang is cut short well above the expected couple of hundred cycles
    always @(posedge I_CLK) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            final_report();
        end
    end

    // ********************************
    // shared tasks
    // ********************************
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [VAL_W-1:0] get_out(input int s);
        case (s)
            SH_FALL: return O_DBFALL;
            SH_RISE: return O_DBRISE;
            SH_CTL:  return O_DBCTL;
            default: return O_GENB;
        endcase
    endfunction

    task automatic chk_all();
        for (int s = 0; s < 4; s++) chk({16'h0, get_out(s)}, {16'h0, act[s]});
    endtask

    task automatic edges(input int n);
        repeat (n) @(posedge I_CLK);
        #1;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge I_CLK);
        I_WR <= 1'b1; I_ADDR <= a; I_WDATA <= d;
        @(posedge I_CLK);
        I_WR <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge I_CLK);
        I_RD <= 1'b1; I_ADDR <= a;
        @(posedge I_CLK);
        I_RD <= 1'b0;
        #1;
        d = O_RDATA;
    endtask

    task automatic pulse(input logic z, input logic s);
        @(posedge I_CLK);
        I_CNT_ZERO <= z; I_SYNC_REQ <= s;
        @(posedge I_CLK);
        I_CNT_ZERO <= 1'b0; I_SYNC_REQ <= 1'b0;
        #1;
    endtask

    // one-cycle comparator event, then count the cycles the fault stands
    task automatic trig_count(output int n);
        @(posedge I_CLK);
        I_CMP_TRIG <= 4'h4;
        @(posedge I_CLK);
        I_CMP_TRIG <= 4'h0;
        n = 0;
        #1;
        // the fault is already up in the cycle right after the event edge
        repeat (12) begin
            if (O_FAULT === 1'b1) n++;
            edges(1);
        end
    endtask

    // ********************************
    // main sequence
    // ********************************
    initial begin
        edges(12);
        I_RST <= 1'b0;
        chk_all();
        rd(OFS_CTL, rdv); chk(rdv, RST_VAL);
        foreach (rows[i]) begin
            ctl = 32'(rows[i].mode) << rows[i].lsb;
            wr(OFS_CTL, ctl);
            rd(OFS_CTL, rdv); chk(rdv, ctl);
            wr(rows[i].addr, {16'h0, rows[i].data});
            if (rows[i].mode < MODE_LOCAL) act[rows[i].slot] = rows[i].data;
            chk_all();
            if (rows[i].mode == MODE_GLOBAL) begin
                pulse(1'b1, 1'b0); chk_all();
                pulse(1'b0, 1'b1); chk_all();
            end
            pulse(1'b1, 1'b0);
            act[rows[i].slot] = rows[i].data;
            chk_all();
            rd(rows[i].addr, rdv); chk(rdv, {16'h0, rows[i].data});
        end
        // reserved bits, unmapped place, read data standing one cycle
        wr(OFS_CTL, 32'hFFFF_FFFF);
        rd(OFS_CTL, rdv); chk(rdv, 32'h0003_FF00);
        wr(OFS_CTL, 32'h0);
        wr(8'h7C, 32'hFFFF_FFFF); chk_all();
        rd(8'h7C, rdv); chk(rdv, 32'h0);
        rd(OFS_FLTIN, rdv); edges(1); chk(O_RDATA, 32'h0);
        // a frozen clock enable must drop the write
        @(posedge I_CLK);
        I_CE <= 1'b0;
        wr(OFS_DBFALL, 32'h0000_5A5A);
        I_CE <= 1'b1;
        chk_all();
        // fault from pin zero only, through the synchroniser
        wr(OFS_FLTIN, 32'hF);
        @(posedge I_CLK); I_FAULT_PIN <= 4'hE; edges(4); chk({31'h0, O_FAULT}, 32'h0);
        @(posedge I_CLK); I_FAULT_PIN <= 4'h1; edges(2); chk({31'h0, O_FAULT}, 32'h0);
        edges(1); chk({31'h0, O_FAULT}, 32'h1);
        @(posedge I_CLK); I_FAULT_PIN <= 4'h0; edges(3); chk({31'h0, O_FAULT}, 32'h0);
        // register-defined source
        wr(OFS_FLTIN, 32'h2); wr(OFS_CMPSRC, 32'h4); wr(OFS_CTL, 32'h1 << CTL_SRC);
        @(posedge I_CLK); I_FAULT_PIN <= 4'hD; edges(4); chk({31'h0, O_FAULT}, 32'h0);
        @(posedge I_CLK); I_FAULT_PIN <= 4'h2; edges(3); chk({31'h0, O_FAULT}, 32'h1);
        @(posedge I_CLK); I_FAULT_PIN <= 4'h0; I_CMP_TRIG <= 4'hB; edges(4);
        chk({31'h0, O_FAULT}, 32'h0);
        trig_count(cnt);
        chk(32'(cnt), 32'h1);
        // stretch to the minimum count plus one
        wr(OFS_MINFLT, 32'h3);
        wr(OFS_CTL, (32'h1 << CTL_MINFLT) | (32'h1 << CTL_SRC));
        trig_count(cnt);
        chk(32'(cnt), 32'h4);
        // clearing the enable aborts a long stretch
        wr(OFS_MINFLT, 32'h40);
        @(posedge I_CLK); I_CMP_TRIG <= 4'h4;
        @(posedge I_CLK); I_CMP_TRIG <= 4'h0;
        edges(5); chk({31'h0, O_FAULT}, 32'h1);
        wr(OFS_CTL, 32'h1 << CTL_SRC); edges(1); chk({31'h0, O_FAULT}, 32'h0);
        // second reset in mid-run clears the active values
        @(posedge I_CLK); I_RST <= 1'b1;
        act = '{default: '0};
        edges(2); chk_all(); chk({31'h0, O_FAULT}, 32'h0);
        I_RST <= 1'b0;
        rd(OFS_CTL, rdv); chk(rdv, RST_VAL);
        final_report();
    end
endmodule
`default_nettype wire
